// [include/lms_regs.svh]
// constants of the led mode sequencer: input bit positions, reset values, timing
// assumes a 40 MHz clock; counts are derived from times in their own units
`ifndef LMS_REGS_SVH
`define LMS_REGS_SVH

// ----------------------------------------
// comparator input positions
// ----------------------------------------
`define LMS_IN_W        9
`define LMS_IN_VCC_ON   0
`define LMS_IN_VCC_LOW  1
`define LMS_IN_CTRL_DIS 2
`define LMS_IN_ADIS     3
`define LMS_IN_EOSS     4
`define LMS_IN_SAG      5
`define LMS_IN_FB_CLAMP 6
`define LMS_IN_STOP     7
`define LMS_IN_PWM      8

// ----------------------------------------
// reset values
// ----------------------------------------
`define LMS_RST_CHG     1'b1
`define LMS_RST_PD      1'b1
`define LMS_RST_GATE    1'b0
`define LMS_RST_PERIPH  1'b0
`define LMS_RST_SS      1'b0

// ----------------------------------------
// timing
// ----------------------------------------
`define LMS_CLK_HZ      64'd40000000
`define LMS_T_SAG_MS    64'd100
`define LMS_T_ADIS_MS   64'd100
`define LMS_T_OPTO_MS   64'd100
`define LMS_T_REC_MS    64'd2500
`define LMS_SAG_CYC     (`LMS_T_SAG_MS * `LMS_CLK_HZ / 64'd1000)
`define LMS_ADIS_CYC    (`LMS_T_ADIS_MS * `LMS_CLK_HZ / 64'd1000)
`define LMS_OPTO_CYC    (`LMS_T_OPTO_MS * `LMS_CLK_HZ / 64'd1000)
`define LMS_REC_CYC     (`LMS_T_REC_MS * `LMS_CLK_HZ / 64'd1000)

`endif

// [include/lms_pkg.sv]
// types of the led mode sequencer: modes, fault causes, state records
// assumes lms_regs.svh is on the include path
`include "lms_regs.svh"

package lms_pkg;

	// ----------------------------------------
	// operating modes, one-hot
	// ----------------------------------------
	typedef enum logic [3:0]
	{
		MODE_STARTUP = 4'h1,
		MODE_ACTIVE  = 4'h2,
		MODE_STOP    = 4'h4,
		MODE_LOWCON  = 4'h8
	} lms_mode_t;

	typedef enum logic [1:0]
	{
		FLT_NONE = 2'h0,
		FLT_SAG  = 2'h1,
		FLT_ADIS = 2'h2,
		FLT_OPTO = 2'h3
	} lms_fault_t;

	// ----------------------------------------
	// state records
	// ----------------------------------------
	typedef struct packed
	{
		lms_mode_t           mode;
		logic [`LMS_IN_W-1:0] s1;
		logic [`LMS_IN_W-1:0] s2;
		logic                ss;
		logic                ss_pend;
		lms_fault_t          fault;
		logic                chg;
		logic                gate;
		logic                pd;
		logic                periph;
	} lms_state_t;

	typedef struct packed
	{
		logic [31:0] cnt;
		logic        done;
	} lms_tmr_t;

endpackage

// [rtl/lms_timer.sv]
// qualification timer: done rises after run has held for LIMIT cycles
// assumes run comes from logic on the same clock
`timescale 1ns/1ps

module lms_timer #(
	parameter int unsigned LIMIT = 32'd4
) (
	input  wire logic clk,
	input  wire logic nrst,
	input  wire logic run,
	output logic      done
);

	lms_pkg::lms_tmr_t r_ff;
	lms_pkg::lms_tmr_t nxt_r;

	// ----------------------------------------
	// counter
	// ----------------------------------------
	always_comb
	begin
		nxt_r = r_ff;
		if (!run)
		begin
			nxt_r.cnt  = 32'h0;
			nxt_r.done = 1'b0;
		end
		else if (r_ff.cnt == LIMIT - 32'h1)
			nxt_r.done = 1'b1;
		else
			nxt_r.cnt = r_ff.cnt + 32'h1;
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			r_ff <= '0;
		else
			r_ff <= nxt_r;
	end

	assign done = r_ff.done;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_timer_exact: assert property (@(posedge clk) disable iff (!nrst)
		$rose(r_ff.done) |-> r_ff.cnt == LIMIT - 32'h1)
		else $error("timer done at wrong count");
	a_timer_clear: assert property (@(posedge clk) disable iff (!nrst)
		!run |=> !r_ff.done && r_ff.cnt == 32'h0)
		else $error("timer not cleared when idle");

endmodule

// [rtl/lms_mode_seq.sv]
// operating-mode sequencer of a quasi-resonant led power controller
// assumes threshold comparator outputs arrive asynchronously and one 40 MHz clock
//
// Notes on behaviour
// - startup on power-up and leaving low consumption
// - startup charges supply, peripherals off
// - startup pulls control pin to ground
// - active mode drives switch from loop request
// - leave active on fault or supply low
// - charger off throughout active mode
// - stop halts switching, resumes without soft-start
// - low consumption halts, schedules soft-start
// - low consumption keeps supply inside hysteresis band
// - soft-start after startup, ends at eoss level
// - soft-start limit follows control pin voltage
// - soft-start ignores opto, sag, analog disable
// - sag declared after 100 ms low current
// - control above 2.6 V stops after 100 ms
// - wait 2.5 s recovery after these faults
// - low consumption pulls control pin low
// - clamped feedback for 100 ms flags opto fail
`timescale 1ns/1ps

`include "lms_regs.svh"

module lms_mode_seq #(
	parameter int unsigned SAG_CYC  = 32'(`LMS_SAG_CYC),
	parameter int unsigned ADIS_CYC = 32'(`LMS_ADIS_CYC),
	parameter int unsigned OPTO_CYC = 32'(`LMS_OPTO_CYC),
	parameter int unsigned REC_CYC  = 32'(`LMS_REC_CYC)
) (
	input  wire logic          clk,
	input  wire logic          nrst,
	input  wire logic          vcc_above_on,
	input  wire logic          vcc_below_low,
	input  wire logic          ctrl_below_dis,
	input  wire logic          ctrl_above_adis,
	input  wire logic          ctrl_above_eoss,
	input  wire logic          zcd_below_sag,
	input  wire logic          fb_clamped,
	input  wire logic          stop_req,
	input  wire logic          pwm_req,
	output lms_pkg::lms_mode_t mode,
	output logic               hv_charger_en,
	output logic               gate_drive,
	output logic               ctrl_pulldown,
	output logic               periph_en,
	output logic               soft_start,
	output lms_pkg::lms_fault_t fault_cause
);

	// ----------------------------------------
	// state and synchronised inputs
	// ----------------------------------------
	lms_pkg::lms_state_t  r_ff;
	lms_pkg::lms_state_t  nxt_r;
	logic [`LMS_IN_W-1:0] raw_in;
	logic                 on_s;
	logic                 low_s;
	logic                 dis_s;
	logic                 adis_s;
	logic                 eoss_s;
	logic                 sag_s;
	logic                 clamp_s;
	logic                 stop_s;
	logic                 pwm_s;
	logic                 sag_done;
	logic                 adis_done;
	logic                 opto_done;
	logic                 rec_done;
	logic                 prot_run;

	assign raw_in = {pwm_req, stop_req, fb_clamped, zcd_below_sag, ctrl_above_eoss,
		ctrl_above_adis, ctrl_below_dis, vcc_below_low, vcc_above_on};

	assign on_s    = r_ff.s2[`LMS_IN_VCC_ON];
	assign low_s   = r_ff.s2[`LMS_IN_VCC_LOW];
	assign dis_s   = r_ff.s2[`LMS_IN_CTRL_DIS];
	assign adis_s  = r_ff.s2[`LMS_IN_ADIS];
	assign eoss_s  = r_ff.s2[`LMS_IN_EOSS];
	assign sag_s   = r_ff.s2[`LMS_IN_SAG];
	assign clamp_s = r_ff.s2[`LMS_IN_FB_CLAMP];
	assign stop_s  = r_ff.s2[`LMS_IN_STOP];
	assign pwm_s   = r_ff.s2[`LMS_IN_PWM];

	// ----------------------------------------
	// protection timers
	// ----------------------------------------
	assign prot_run = (r_ff.mode == lms_pkg::MODE_ACTIVE) && !r_ff.ss;

	lms_timer #(.LIMIT(SAG_CYC)) u_sag_tmr (
		.clk  (clk),
		.nrst (nrst),
		.run  (prot_run && sag_s),
		.done (sag_done)
	);

	lms_timer #(.LIMIT(ADIS_CYC)) u_adis_tmr (
		.clk  (clk),
		.nrst (nrst),
		.run  (prot_run && adis_s),
		.done (adis_done)
	);

	lms_timer #(.LIMIT(OPTO_CYC)) u_opto_tmr (
		.clk  (clk),
		.nrst (nrst),
		.run  (prot_run && clamp_s),
		.done (opto_done)
	);

	lms_timer #(.LIMIT(REC_CYC)) u_rec_tmr (
		.clk  (clk),
		.nrst (nrst),
		.run  ((r_ff.mode == lms_pkg::MODE_LOWCON) && (r_ff.fault != lms_pkg::FLT_NONE)),
		.done (rec_done)
	);

	// ----------------------------------------
	// mode sequencing
	// ----------------------------------------
	always_comb
	begin
		nxt_r    = r_ff;
		nxt_r.s1 = raw_in;
		nxt_r.s2 = r_ff.s1;
		unique case (r_ff.mode)
			lms_pkg::MODE_STARTUP:
			begin
				if (on_s)
				begin
					nxt_r.mode    = lms_pkg::MODE_ACTIVE;
					nxt_r.ss      = 1'b1;
					nxt_r.ss_pend = 1'b0;
				end
			end
			lms_pkg::MODE_ACTIVE:
			begin
				if (r_ff.ss && eoss_s)
					nxt_r.ss = 1'b0;
				if (low_s)
					nxt_r.mode = lms_pkg::MODE_STARTUP;
				else if (sag_done || adis_done || opto_done)
				begin
					nxt_r.mode    = lms_pkg::MODE_LOWCON;
					nxt_r.ss_pend = 1'b1;
					nxt_r.ss      = 1'b0;
					if (sag_done)
						nxt_r.fault = lms_pkg::FLT_SAG;
					else if (adis_done)
						nxt_r.fault = lms_pkg::FLT_ADIS;
					else
						nxt_r.fault = lms_pkg::FLT_OPTO;
				end
				else if (dis_s)
				begin
					nxt_r.mode    = lms_pkg::MODE_LOWCON;
					nxt_r.ss_pend = 1'b1;
					nxt_r.ss      = 1'b0;
					nxt_r.fault   = lms_pkg::FLT_NONE;
				end
				else if (stop_s)
				begin
					nxt_r.mode = lms_pkg::MODE_STOP;
					nxt_r.ss   = 1'b0;
				end
			end
			lms_pkg::MODE_STOP:
			begin
				if (low_s)
					nxt_r.mode = lms_pkg::MODE_STARTUP;
				else if (dis_s)
				begin
					nxt_r.mode    = lms_pkg::MODE_LOWCON;
					nxt_r.ss_pend = 1'b1;
					nxt_r.fault   = lms_pkg::FLT_NONE;
				end
				else if (!stop_s)
					nxt_r.mode = lms_pkg::MODE_ACTIVE;
			end
			lms_pkg::MODE_LOWCON:
			begin
				nxt_r.ss_pend = 1'b1;
				if ((r_ff.fault != lms_pkg::FLT_NONE) ? rec_done : !dis_s)
				begin
					nxt_r.mode  = lms_pkg::MODE_STARTUP;
					nxt_r.fault = lms_pkg::FLT_NONE;
				end
			end
			default:
				nxt_r.mode = lms_pkg::MODE_STARTUP;
		endcase

		// outputs follow the next mode so they change with it
		nxt_r.gate   = (nxt_r.mode == lms_pkg::MODE_ACTIVE) && pwm_s;
		nxt_r.periph = (nxt_r.mode != lms_pkg::MODE_STARTUP);
		nxt_r.pd     = (nxt_r.mode == lms_pkg::MODE_STARTUP)
			|| (nxt_r.mode == lms_pkg::MODE_LOWCON);
		unique case (nxt_r.mode)
			lms_pkg::MODE_STARTUP:
				nxt_r.chg = 1'b1;
			lms_pkg::MODE_LOWCON:
			begin
				if (low_s)
					nxt_r.chg = 1'b1;
				else if (on_s)
					nxt_r.chg = 1'b0;
			end
			default:
				nxt_r.chg = 1'b0;
		endcase
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			r_ff         <= '0;
			r_ff.mode    <= lms_pkg::MODE_STARTUP;
			r_ff.chg     <= `LMS_RST_CHG;
			r_ff.pd      <= `LMS_RST_PD;
			r_ff.gate    <= `LMS_RST_GATE;
			r_ff.periph  <= `LMS_RST_PERIPH;
			r_ff.ss      <= `LMS_RST_SS;
			r_ff.fault   <= lms_pkg::FLT_NONE;
		end
		else
			r_ff <= nxt_r;
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign mode          = r_ff.mode;
	assign hv_charger_en = r_ff.chg;
	assign gate_drive    = r_ff.gate;
	assign ctrl_pulldown = r_ff.pd;
	assign periph_en     = r_ff.periph;
	assign soft_start    = r_ff.ss;
	assign fault_cause   = r_ff.fault;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_startup_outputs: assert property (@(posedge clk) disable iff (!nrst)
		r_ff.mode == lms_pkg::MODE_STARTUP |-> r_ff.chg && r_ff.pd && !r_ff.gate && !r_ff.periph)
		else $error("startup outputs wrong");

	a_turn_on_entry: assert property (@(posedge clk) disable iff (!nrst)
		r_ff.mode == lms_pkg::MODE_STARTUP && on_s
		|=> r_ff.mode == lms_pkg::MODE_ACTIVE && !r_ff.chg && r_ff.ss)
		else $error("turn-on did not enter active with soft-start");

	a_active_charger: assert property (@(posedge clk) disable iff (!nrst)
		r_ff.mode == lms_pkg::MODE_ACTIVE |-> !r_ff.chg)
		else $error("charger on in active mode");

	a_gate_active: assert property (@(posedge clk) disable iff (!nrst)
		r_ff.gate |-> r_ff.mode == lms_pkg::MODE_ACTIVE && $past(r_ff.s2[`LMS_IN_PWM]))
		else $error("gate driven outside active mode");

	a_supply_low_exit: assert property (@(posedge clk) disable iff (!nrst)
		r_ff.mode == lms_pkg::MODE_ACTIVE && low_s |=> r_ff.mode == lms_pkg::MODE_STARTUP)
		else $error("supply low did not leave active");

	a_ss_masks_prot: assert property (@(posedge clk) disable iff (!nrst)
		r_ff.ss |-> !sag_done && !adis_done && !opto_done)
		else $error("protection timer ran during soft-start");

	a_stop_resume: assert property (@(posedge clk) disable iff (!nrst)
		r_ff.mode == lms_pkg::MODE_STOP && !stop_s && !low_s && !dis_s
		|=> r_ff.mode == lms_pkg::MODE_ACTIVE && !r_ff.ss)
		else $error("stop did not resume without soft-start");

	a_lowcon_charge: assert property (@(posedge clk) disable iff (!nrst)
		r_ff.mode == lms_pkg::MODE_LOWCON && low_s ##1 r_ff.mode == lms_pkg::MODE_LOWCON
		|-> r_ff.chg)
		else $error("charger off below band in low consumption");

	a_lowcon_pd: assert property (@(posedge clk) disable iff (!nrst)
		r_ff.mode == lms_pkg::MODE_LOWCON |-> r_ff.pd && !r_ff.gate && r_ff.ss_pend)
		else $error("low consumption outputs wrong");

	a_recovery_hold: assert property (@(posedge clk) disable iff (!nrst)
		r_ff.mode == lms_pkg::MODE_LOWCON && r_ff.fault != lms_pkg::FLT_NONE && !rec_done
		|=> r_ff.mode == lms_pkg::MODE_LOWCON)
		else $error("left low consumption before recovery time");

	a_disable_entry: assert property (@(posedge clk) disable iff (!nrst)
		r_ff.mode == lms_pkg::MODE_ACTIVE && dis_s && !low_s && !sag_done && !adis_done
		&& !opto_done |=> r_ff.mode == lms_pkg::MODE_LOWCON && !r_ff.gate)
		else $error("disable did not enter low consumption");

	a_ss_end: assert property (@(posedge clk) disable iff (!nrst)
		r_ff.mode == lms_pkg::MODE_ACTIVE && r_ff.ss && eoss_s |=> !r_ff.ss)
		else $error("soft-start did not end at eoss");

	a_stop_outputs: assert property (@(posedge clk) disable iff (!nrst)
		r_ff.mode == lms_pkg::MODE_STOP |-> !r_ff.gate && !r_ff.chg && !r_ff.ss && r_ff.periph)
		else $error("stop mode outputs wrong");

	a_stop_entry: assert property (@(posedge clk) disable iff (!nrst)
		r_ff.mode == lms_pkg::MODE_ACTIVE && stop_s && !low_s && !dis_s && !sag_done
		&& !adis_done && !opto_done |=> r_ff.mode == lms_pkg::MODE_STOP && !r_ff.gate)
		else $error("abnormal condition did not stop switching");

	a_lowcon_full: assert property (@(posedge clk) disable iff (!nrst)
		r_ff.mode == lms_pkg::MODE_LOWCON && on_s && !low_s
		##1 r_ff.mode == lms_pkg::MODE_LOWCON |-> !r_ff.chg)
		else $error("charger on above band in low consumption");

	a_sag_code: assert property (@(posedge clk) disable iff (!nrst)
		r_ff.mode == lms_pkg::MODE_ACTIVE && !low_s && sag_done
		|=> r_ff.mode == lms_pkg::MODE_LOWCON && r_ff.fault == lms_pkg::FLT_SAG)
		else $error("supply sag not flagged");

	a_adis_code: assert property (@(posedge clk) disable iff (!nrst)
		r_ff.mode == lms_pkg::MODE_ACTIVE && !low_s && !sag_done && adis_done
		|=> r_ff.mode == lms_pkg::MODE_LOWCON && r_ff.fault == lms_pkg::FLT_ADIS)
		else $error("timed disable not flagged");

	a_opto_code: assert property (@(posedge clk) disable iff (!nrst)
		r_ff.mode == lms_pkg::MODE_ACTIVE && !low_s && !sag_done && !adis_done && opto_done
		|=> r_ff.mode == lms_pkg::MODE_LOWCON && r_ff.fault == lms_pkg::FLT_OPTO)
		else $error("opto failure not flagged");

	a_recovery_exit: assert property (@(posedge clk) disable iff (!nrst)
		r_ff.mode == lms_pkg::MODE_LOWCON && r_ff.fault != lms_pkg::FLT_NONE && rec_done
		|=> r_ff.mode == lms_pkg::MODE_STARTUP && r_ff.fault == lms_pkg::FLT_NONE && r_ff.chg)
		else $error("recovery end did not restart");

	a_disable_resume: assert property (@(posedge clk) disable iff (!nrst)
		r_ff.mode == lms_pkg::MODE_LOWCON && r_ff.fault == lms_pkg::FLT_NONE && !dis_s
		|=> r_ff.mode == lms_pkg::MODE_STARTUP)
		else $error("disable release did not restart");

	a_active_outputs: assert property (@(posedge clk) disable iff (!nrst)
		r_ff.mode == lms_pkg::MODE_ACTIVE |-> r_ff.periph && !r_ff.pd)
		else $error("active mode outputs wrong");

	a_ss_start: assert property (@(posedge clk) disable iff (!nrst)
		$rose(r_ff.ss) |-> r_ff.mode == lms_pkg::MODE_ACTIVE
		&& $past(r_ff.mode) == lms_pkg::MODE_STARTUP)
		else $error("soft-start began outside startup exit");

	a_fault_clear: assert property (@(posedge clk) disable iff (!nrst)
		r_ff.mode != lms_pkg::MODE_LOWCON |-> r_ff.fault == lms_pkg::FLT_NONE)
		else $error("fault cause held outside low consumption");

	a_dis_stop: assert property (@(posedge clk) disable iff (!nrst)
		r_ff.mode == lms_pkg::MODE_STOP && !low_s && dis_s
		|=> r_ff.mode == lms_pkg::MODE_LOWCON && r_ff.fault == lms_pkg::FLT_NONE)
		else $error("disable in stop did not enter low consumption");

	a_startup_hold: assert property (@(posedge clk) disable iff (!nrst)
		r_ff.mode == lms_pkg::MODE_STARTUP && !on_s
		|=> r_ff.mode == lms_pkg::MODE_STARTUP && r_ff.chg)
		else $error("startup left below turn-on");

	// ----------------------------------------
	// coverage
	// ----------------------------------------
	c_startup_active: cover property (@(posedge clk) disable iff (!nrst)
		r_ff.mode == lms_pkg::MODE_STARTUP ##1 r_ff.mode == lms_pkg::MODE_ACTIVE);
	c_fault_lowcon: cover property (@(posedge clk) disable iff (!nrst)
		r_ff.mode == lms_pkg::MODE_LOWCON && r_ff.fault == lms_pkg::FLT_SAG);
	c_stop_resume: cover property (@(posedge clk) disable iff (!nrst)
		r_ff.mode == lms_pkg::MODE_STOP ##1 r_ff.mode == lms_pkg::MODE_ACTIVE);
	c_ss_done: cover property (@(posedge clk) disable iff (!nrst)
		$fell(r_ff.ss) && r_ff.mode == lms_pkg::MODE_ACTIVE);
	c_stop_in_ss: cover property (@(posedge clk) disable iff (!nrst)
		r_ff.mode == lms_pkg::MODE_ACTIVE && r_ff.ss ##1 r_ff.mode == lms_pkg::MODE_STOP);

endmodule

// [testbench/lms_plant_model.sv]
// model of supply capacitor and control pin network
// assumes charger and pull-down levels from the sequencer, drain from the bench
`timescale 1ns/1ps

module lms_plant_model (
	input  wire logic clk,
	input  wire logic hv_charger_en,
	input  wire logic ctrl_pulldown,
	input  wire logic drain,
	output logic      vcc_above_on,
	output logic      vcc_below_low,
	output logic      ctrl_above_eoss
);
	int vcc = 0;
	int ctl = 0;

	// ----------------------------------------
	// supply and control pin levels
	// ----------------------------------------
	always @(negedge clk)
	begin
		vcc = vcc + (hv_charger_en ? 2 : 0) - (drain ? 1 : 0);
		if (vcc > 100)
			vcc = 100;
		if (vcc < 0)
			vcc = 0;
		if (ctrl_pulldown)
			ctl = 0;
		else if (ctl < 50)
			ctl = ctl + 1;
	end

	assign vcc_above_on    = (vcc >= 80);
	assign vcc_below_low   = (vcc < 40);
	assign ctrl_above_eoss = (ctl >= 30);
endmodule

// [testbench/lms_mode_seq_tb_top.sv]
// self-checking bench of the led mode sequencer
// assumes lms_pkg compiled first and the plant model beside it
`timescale 1ns/1ps

module lms_mode_seq_tb_top;
	logic                clk;
	logic                nrst;
	logic                ctrl_below_dis;
	logic                ctrl_above_adis;
	logic                zcd_below_sag;
	logic                fb_clamped;
	logic                stop_req;
	logic                pwm_req;
	logic                drain;
	wire logic           vcc_above_on;
	wire logic           vcc_below_low;
	wire logic           ctrl_above_eoss;
	lms_pkg::lms_mode_t  mode;
	logic                hv_charger_en;
	logic                gate_drive;
	logic                ctrl_pulldown;
	logic                periph_en;
	logic                soft_start;
	lms_pkg::lms_fault_t fault_cause;
	int                  miscompares = 0;
	int                  total_checks = 0;
	int                  waited;

	localparam int T_PROT = 8;
	localparam int T_REC  = 20;

	lms_mode_seq #(.SAG_CYC(T_PROT), .ADIS_CYC(T_PROT), .OPTO_CYC(T_PROT), .REC_CYC(T_REC)) uut (
		.clk             (clk),
		.nrst            (nrst),
		.vcc_above_on    (vcc_above_on),
		.vcc_below_low   (vcc_below_low),
		.ctrl_below_dis  (ctrl_below_dis),
		.ctrl_above_adis (ctrl_above_adis),
		.ctrl_above_eoss (ctrl_above_eoss),
		.zcd_below_sag   (zcd_below_sag),
		.fb_clamped      (fb_clamped),
		.stop_req        (stop_req),
		.pwm_req         (pwm_req),
		.mode            (mode),
		.hv_charger_en   (hv_charger_en),
		.gate_drive      (gate_drive),
		.ctrl_pulldown   (ctrl_pulldown),
		.periph_en       (periph_en),
		.soft_start      (soft_start),
		.fault_cause     (fault_cause)
	);

	lms_plant_model plant (
		.clk             (clk),
		.hv_charger_en   (hv_charger_en),
		.ctrl_pulldown   (ctrl_pulldown),
		.drain           (drain),
		.vcc_above_on    (vcc_above_on),
		.vcc_below_low   (vcc_below_low),
		.ctrl_above_eoss (ctrl_above_eoss)
	);

	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic complete_run;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// sel 0 mode, 1 soft_start, 2 charger
	task automatic wait_for(input int sel, input logic [3:0] v);
		waited = 0;
		while (!((sel == 0 && mode === v) || (sel == 1 && soft_start === v[0]) ||
			(sel == 2 && hv_charger_en === v[0])))
		begin
			@(negedge clk);
			waited++;
			if (waited > 3000)
			begin
				miscompares++;
				complete_run();
			end
		end
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic reset_values;
		check(mode, lms_pkg::MODE_STARTUP);
		check(hv_charger_en, 1'b1);
		check(ctrl_pulldown, 1'b1);
		check(periph_en, 1'b0);
		check(gate_drive, 1'b0);
		check(soft_start, 1'b0);
		check(fault_cause, lms_pkg::FLT_NONE);
	endtask

	task automatic start_to_active;
		wait_for(0, lms_pkg::MODE_ACTIVE);
		check(hv_charger_en, 1'b0);
		check(ctrl_pulldown, 1'b0);
		check(soft_start, 1'b1);
		check(periph_en, 1'b1);
		wait_for(1, 4'h0);
		check(ctrl_above_eoss, 1'b1);
		check(hv_charger_en, 1'b0);
		pwm_req = 1'b1;
		repeat (4) @(negedge clk);
		check(gate_drive, 1'b1);
		pwm_req = 1'b0;
		repeat (4) @(negedge clk);
		check(gate_drive, 1'b0);
	endtask

	task automatic stop_resume;
		pwm_req = 1'b1;
		stop_req = 1'b1;
		repeat (3) @(negedge clk);
		check(mode, lms_pkg::MODE_STOP);
		check(gate_drive, 1'b0);
		stop_req = 1'b0;
		repeat (3) @(negedge clk);
		check(mode, lms_pkg::MODE_ACTIVE);
		check(soft_start, 1'b0);
		@(negedge clk);
		check(gate_drive, 1'b1);
		pwm_req = 1'b0;
	endtask

	task automatic disable_lowcon;
		ctrl_below_dis = 1'b1;
		repeat (3) @(negedge clk);
		check(mode, lms_pkg::MODE_LOWCON);
		check(fault_cause, lms_pkg::FLT_NONE);
		check(ctrl_pulldown, 1'b1);
		check(gate_drive, 1'b0);
		drain = 1'b1;
		wait_for(2, 4'h1);
		check(vcc_above_on, 1'b0);
		wait_for(2, 4'h0);
		check(mode, lms_pkg::MODE_LOWCON);
		drain = 1'b0;
		ctrl_below_dis = 1'b0;
		repeat (3) @(negedge clk);
		check(mode, lms_pkg::MODE_STARTUP);
	endtask

	task automatic fault_loop;
		lms_pkg::lms_fault_t codes[3];
		codes = '{lms_pkg::FLT_SAG, lms_pkg::FLT_ADIS, lms_pkg::FLT_OPTO};
		for (int i = 0; i < 3; i++)
		begin
			wait_for(0, lms_pkg::MODE_ACTIVE);
			check(soft_start, 1'b1);
			zcd_below_sag = (i == 0);
			ctrl_above_adis = (i == 1);
			fb_clamped = (i == 2);
			wait_for(1, 4'h0);
			check(mode, lms_pkg::MODE_ACTIVE);
			wait_for(0, lms_pkg::MODE_LOWCON);
			check(waited, T_PROT + 1);
			check(fault_cause, codes[i]);
			check(gate_drive, 1'b0);
			check(ctrl_pulldown, 1'b1);
			zcd_below_sag = 1'b0;
			ctrl_above_adis = 1'b0;
			fb_clamped = 1'b0;
			wait_for(0, lms_pkg::MODE_STARTUP);
			check(waited, T_REC + 1);
		end
	endtask

	task automatic supply_low;
		wait_for(0, lms_pkg::MODE_ACTIVE);
		drain = 1'b1;
		wait_for(0, lms_pkg::MODE_STARTUP);
		check(gate_drive, 1'b0);
		check(hv_charger_en, 1'b1);
		drain = 1'b0;
		wait_for(0, lms_pkg::MODE_ACTIVE);
		check(soft_start, 1'b1);
	endtask

	task automatic stop_in_soft_start;
		stop_req = 1'b1;
		repeat (3) @(negedge clk);
		check(mode, lms_pkg::MODE_STOP);
		check(soft_start, 1'b0);
		stop_req = 1'b0;
		repeat (3) @(negedge clk);
		check(mode, lms_pkg::MODE_ACTIVE);
		check(soft_start, 1'b0);
	endtask

	task automatic reset_mid_run;
		nrst = 1'b0;
		@(negedge clk);
		reset_values();
		nrst = 1'b1;
		wait_for(0, lms_pkg::MODE_ACTIVE);
		check(soft_start, 1'b1);
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		nrst = 1'b0;
		ctrl_below_dis = 1'b0;
		ctrl_above_adis = 1'b0;
		zcd_below_sag = 1'b0;
		fb_clamped = 1'b0;
		stop_req = 1'b0;
		pwm_req = 1'b0;
		drain = 1'b0;
		repeat (2) @(negedge clk);
		reset_values();
		@(negedge clk);
		nrst = 1'b1;
		start_to_active();
		stop_resume();
		disable_lowcon();
		fault_loop();
		supply_low();
		stop_in_soft_start();
		reset_mid_run();
		complete_run();
	end
endmodule
